//--- arpm_top.sv
// apb register block for converter reference select and analogue pin masks
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "arpm_cfg.svh"
// Function
// - reset gives supply positive, ground negative
// - x2 encoding: bits3..2 positive, 1..0 negative
// - m2 encoding: bits1..0 positive select
// - m2 bit2 selects external negative
// - set mask bit isolates digital buffer
// - conversion or touch use sets bit
// - low word bits 0..14 channels
// - high word bits 0..11 channels 16..27
// - mask words read and write freely
// - converter connected to pin from first enabled clock after reset; reset disconnects it
module arpm_top #(
  parameter int NUM_CH = 28
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire arpm_pkg::arpm_use_t chan_use,
  input wire logic auto_mask_en,
  output arpm_pkg::arpm_ref_t ref_sel,
  output logic [NUM_CH-1:0] dig_buf_off,
  output logic [NUM_CH-1:0] adc_connect
);
  import arpm_pkg::*;

  // ----------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------
  // the mask words carry channels 0..27 only; any other count is refused with an elaboration error
  if (NUM_CH != `ARPM_NUM_CH) begin : g_bad_num_ch
    $error("arpm_top: NUM_CH must be 28");
  end

  // ----------------------------------------------------------
  // register state
  // ----------------------------------------------------------
  logic [4:0] ref_cfg_r;
  logic [4:0] ref_cfg_nxt;
  logic [15:0] mask_lo_r;
  logic [15:0] mask_lo_nxt;
  logic [15:0] mask_hi_r;
  logic [15:0] mask_hi_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  arpm_ref_t ref_r;
  arpm_ref_t ref_nxt;
  logic [NUM_CH-1:0] buf_off_r;
  logic [NUM_CH-1:0] buf_off_nxt;
  logic [15:0] auto_lo;
  logic [15:0] auto_hi;
  logic acc;
  logic wr;
  logic mapped;
  logic setup;
  logic ref_hit;
  logic lo_hit;
  logic hi_hit;
  logic [`ARPM_MASK_W-1:0] lo_written;
  logic [`ARPM_MASK_W-1:0] hi_written;
  logic pready_nxt;
  logic [NUM_CH-1:0] adc_connect_nxt;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  // keep clk_en high across a transfer: a frozen pready would let the
  // master finish an access that the registers never took
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign ref_hit = wr && (paddr == `ARPM_OFF_REF_CFG) && pstrb[0];
  assign lo_hit = wr && (paddr == `ARPM_OFF_MASK_LO);
  assign hi_hit = wr && (paddr == `ARPM_OFF_MASK_HI);

  always_comb begin
    unique case (paddr)
      `ARPM_OFF_REF_CFG,
      `ARPM_OFF_MASK_LO,
      `ARPM_OFF_MASK_HI,
      `ARPM_OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // automatic mask setting
  // ----------------------------------------------------------
  always_comb begin
    auto_lo = 16'h0000;
    auto_hi = 16'h0000;
    if (chan_use.valid && auto_mask_en) begin
      if (chan_use.channel < 5'(`ARPM_HI_BASE)) begin
        auto_lo[chan_use.channel[3:0]] = 1'b1;
      end else begin
        auto_hi[chan_use.channel[3:0]] = 1'b1;
      end
    end
    auto_lo = auto_lo & `ARPM_LO_USED;
    auto_hi = auto_hi & `ARPM_HI_USED;
  end

  // ----------------------------------------------------------
  // register next values
  // ----------------------------------------------------------
  always_comb begin
    ref_cfg_nxt = ref_cfg_r;
    mask_lo_nxt = mask_lo_r;
    mask_hi_nxt = mask_hi_r;
    if (ref_hit) begin
      ref_cfg_nxt = pwdata[4:0];
    end
    mask_lo_nxt = (lo_written | auto_lo) & `ARPM_LO_USED;
    mask_hi_nxt = (hi_written | auto_hi) & `ARPM_HI_USED;
  end

  // one lane merge per mask word keeps strobe handling in one place
  // byte-lane writes
  arpm_lane_wr #(
    .WIDTH(`ARPM_MASK_W)
  ) u_lo_wr (
    .old_val(mask_lo_r),
    .new_val(pwdata[`ARPM_MASK_W-1:0]),
    .lane_en(pstrb[`ARPM_MASK_W/`ARPM_LANE_BITS-1:0]),
    .hit(lo_hit),
    .merged(lo_written)
  );

  arpm_lane_wr #(
    .WIDTH(`ARPM_MASK_W)
  ) u_hi_wr (
    .old_val(mask_hi_r),
    .new_val(pwdata[`ARPM_MASK_W-1:0]),
    .lane_en(pstrb[`ARPM_MASK_W/`ARPM_LANE_BITS-1:0]),
    .hit(hi_hit),
    .merged(hi_written)
  );

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    // unmapped refused
    // decoded in the setup cycle so data and error stand with pready
    if (setup && !mapped) begin
      pslverr_nxt = 1'b1;
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        `ARPM_OFF_REF_CFG: prdata_nxt = {27'h0, ref_cfg_r};
        `ARPM_OFF_MASK_LO: prdata_nxt = {16'h0, mask_lo_r};
        `ARPM_OFF_MASK_HI: prdata_nxt = {16'h0, mask_hi_r};
        `ARPM_OFF_STATUS: prdata_nxt = {28'h0, ref_r.pos, ref_r.neg};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // reference decode
  // ----------------------------------------------------------
  always_comb begin
    // reserved codes pass through as bad; the analogue side must not trust them
    if (ref_cfg_r[`ARPM_MODE_BIT]) begin
      unique case (ref_cfg_r[`ARPM_M2_POS_HI:`ARPM_M2_POS_LO])
        2'h0: ref_nxt.pos = ARPM_POS_SUPPLY;
        2'h2: ref_nxt.pos = ARPM_POS_EXT;
        2'h3: ref_nxt.pos = ARPM_POS_FIXED;
        default: ref_nxt.pos = ARPM_POS_BAD;
      endcase
      ref_nxt.neg = ref_cfg_r[`ARPM_M2_NEG_BIT] ? ARPM_NEG_EXT : ARPM_NEG_GROUND;
    end else begin
      unique case (ref_cfg_r[`ARPM_X2_POS_HI:`ARPM_X2_POS_LO])
        2'h0: ref_nxt.pos = ARPM_POS_SUPPLY;
        2'h1: ref_nxt.pos = ARPM_POS_EXT;
        2'h2: ref_nxt.pos = ARPM_POS_FIXED;
        default: ref_nxt.pos = ARPM_POS_BAD;
      endcase
      unique case (ref_cfg_r[`ARPM_X2_NEG_HI:`ARPM_X2_NEG_LO])
        2'h0: ref_nxt.neg = ARPM_NEG_GROUND;
        2'h1: ref_nxt.neg = ARPM_NEG_EXT;
        default: ref_nxt.neg = ARPM_NEG_BAD;
      endcase
    end
  end

  // ----------------------------------------------------------
  // pin control
  // ----------------------------------------------------------
  // bit 15 of the low word carries no channel and always reads zero
  always_comb begin
    buf_off_nxt = {mask_hi_r[NUM_CH-`ARPM_HI_BASE-1:0], mask_lo_r[`ARPM_HI_BASE-1:0]};
  end

  // ----------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cfg_r <= {1'b0, `ARPM_REF_RESET};
      ref_r <= {ARPM_POS_SUPPLY, ARPM_NEG_GROUND};
      mask_lo_r <= `ARPM_MASK_RESET;
      mask_hi_r <= `ARPM_MASK_RESET;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      buf_off_r <= '0;
    end else if (clk_en) begin
      ref_cfg_r <= ref_cfg_nxt;
      ref_r <= ref_nxt;
      mask_lo_r <= mask_lo_nxt;
      mask_hi_r <= mask_hi_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      buf_off_r <= buf_off_nxt;
    end
  end

  // ----------------------------------------------------------
  // bus handshake and converter connection
  // ----------------------------------------------------------
  // the answer is registered in the setup cycle, so pready is high
  // in the first access cycle together with the read data
  always_comb begin
    pready_nxt = setup;
    adc_connect_nxt = '1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      adc_connect <= '0;
    end else if (clk_en) begin
      pready <= pready_nxt;
      adc_connect <= adc_connect_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign ref_sel = ref_r;
  assign dig_buf_off = buf_off_r;
endmodule : arpm_top

// ----------------------------------------------------------
// byte-lane merge
// ----------------------------------------------------------
// lanes without a strobe keep their old bits, so software can update
// one byte of a mask word without a read-modify-write on the bus
module arpm_lane_wr #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] old_val,
  input wire logic [WIDTH-1:0] new_val,
  input wire logic [(WIDTH/`ARPM_LANE_BITS)-1:0] lane_en,
  input wire logic hit,
  output logic [WIDTH-1:0] merged
);
  import arpm_pkg::*;
  localparam int LB = `ARPM_LANE_BITS;
  localparam int LANES = WIDTH / LB;

  if ((WIDTH % LB) != 0) begin : g_bad_width
    $error("arpm_lane_wr: WIDTH must be a whole number of bytes");
  end

  always_comb begin
    merged = old_val;
    for (int i = 0; i < LANES; i++) begin
      if (hit && lane_en[i]) begin
        merged[i*LB +: LB] = new_val[i*LB +: LB];
      end
    end
  end
endmodule : arpm_lane_wr
`default_nettype wire

//--- arpm_cfg.svh
// register offsets, field positions and reset values for the reference and pin mask block
`ifndef ARPM_CFG_SVH
`define ARPM_CFG_SVH
`define ARPM_OFF_REF_CFG 12'h000
`define ARPM_OFF_MASK_LO 12'h004
`define ARPM_OFF_MASK_HI 12'h008
`define ARPM_OFF_STATUS 12'h00C
`define ARPM_REF_RESET 4'h0
`define ARPM_MASK_RESET 16'h0000
`define ARPM_LO_USED 16'h7FFF
`define ARPM_HI_USED 16'h0FFF
`define ARPM_HI_BASE 16
`define ARPM_MODE_BIT 4
`define ARPM_X2_POS_HI 3
`define ARPM_X2_POS_LO 2
`define ARPM_X2_NEG_HI 1
`define ARPM_X2_NEG_LO 0
`define ARPM_M2_NEG_BIT 2
`define ARPM_M2_POS_HI 1
`define ARPM_M2_POS_LO 0
`define ARPM_NUM_CH 28
`define ARPM_MASK_W 16
`define ARPM_LANE_BITS 8
`endif

//--- arpm_pkg.sv
// types shared by the reference and pin mask block
package arpm_pkg;
  typedef enum logic [1:0] {
    ARPM_POS_SUPPLY = 2'h0,
    ARPM_POS_EXT = 2'h1,
    ARPM_POS_FIXED = 2'h2,
    ARPM_POS_BAD = 2'h3
  } arpm_pos_t;
  typedef enum logic [1:0] {
    ARPM_NEG_GROUND = 2'h0,
    ARPM_NEG_EXT = 2'h1,
    ARPM_NEG_BAD = 2'h2
  } arpm_neg_t;
  typedef struct packed {
    logic valid;
    logic [4:0] channel;
  } arpm_use_t;
  typedef struct packed {
    arpm_pos_t pos;
    arpm_neg_t neg;
  } arpm_ref_t;
endpackage : arpm_pkg

//--- arpm_assertions.sv
// assertion checker for the reference and pin mask block
`timescale 1ns/1ps
`default_nettype none
module arpm_assertions #(
  parameter int NUM_CH = 28
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire arpm_pkg::arpm_use_t chan_use,
  input wire logic auto_mask_en,
  input wire arpm_pkg::arpm_ref_t ref_sel,
  input wire logic [NUM_CH-1:0] dig_buf_off,
  input wire logic [NUM_CH-1:0] adc_connect
);
  import arpm_pkg::*;
  // ----------
  // port checks
  // ----------
  // full-word writes only, so partial lanes never mislead the mask checks
  wire logic wr = psel && penable && pready && pwrite && clk_en && &pstrb;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (psel && !penable && clk_en |=> pready)
    else $error("late ready");
  chk_err_map: assert property (psel && !penable && clk_en |=> pslverr ==
    !($past(paddr) inside {12'h000, 12'h004, 12'h008, 12'h00C})) else $error("bad slverr");
  chk_conn_all: assert property ($past(presetn) |-> &adc_connect)
    else $error("adc cut");
  chk_bit15_low: assert property (!dig_buf_off[15])
    else $error("bit 15 set");
  chk_use_sets: assert property (chan_use.valid && auto_mask_en && clk_en &&
    chan_use.channel != 15 && chan_use.channel < NUM_CH |->
    ##2 dig_buf_off[$past(chan_use.channel, 2)]) else $error("no auto set");
  chk_m2_neg: assert property (wr && paddr == 12'h000 && pwdata[4] |-> ##2
    ref_sel.neg == {1'b0, $past(pwdata[2], 2)}) else $error("neg ref");
  chk_mask_lo: assert property (wr && paddr == 12'h004 && !chan_use.valid |-> ##2
    dig_buf_off[14:0] == $past(pwdata[14:0], 2)) else $error("low buffers");
  chk_mask_hi: assert property (wr && paddr == 12'h008 && !chan_use.valid |-> ##2
    dig_buf_off[27:16] == $past(pwdata[11:0], 2)) else $error("high buffers");
  cover property (wr && paddr == 12'h000);
  cover property (chan_use.valid && auto_mask_en);
  cover property (pready && pslverr);
endmodule : arpm_assertions
bind arpm_top arpm_assertions #(.NUM_CH(NUM_CH)) u_chk (.*);
`default_nettype wire

//--- arpm_tb_top.sv
// self-checking bench for the reference and pin mask block
`timescale 1ns/1ps
`default_nettype none
module arpm_tb_top;
  import arpm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, auto_mask_en = 0, s;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, m;
  logic [3:0] e;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr;
  arpm_use_t chan_use = 6'h00;
  arpm_ref_t ref_sel;
  logic [27:0] dig_buf_off, adc_connect;
  logic clk_en = 1'b1;
  int err_total = 0, check_count = 0, seed = 32'hFCE3E1BD;
  arpm_top dut (.*);
  always #2.5 pclk = ~pclk;
  // ----------
  // tasks
  // ----------
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // reference decode expected from the encoding tables
  function automatic logic [3:0] exp_ref(logic [4:0] c);
    logic [1:0] p, g;
    p = c[4] ? (c[1:0] == 2'h1 ? 2'h3 : (c[1] ? c[1:0] - 2'h1 : 2'h0)) : c[3:2];
    g = c[4] ? {1'b0, c[2]} : (c[1] ? 2'h2 : c[1:0]);
    return {p, g};
  endfunction : exp_ref
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 16; a += 4) begin
      apb(0, 12'(a), 0);
      chk("reset reg", 0, q);
    end
    chk("ref", 0, ref_sel);
    chk("conn", 28'hFFFFFFF, adc_connect);
    for (int c = 0; c < 32; c++) begin
      e = exp_ref(5'(c));
      if (e[3:2] == 2'h3 || e[1:0] == 2'h2) continue;
      apb(1, 12'h000, c);
      apb(0, 12'h00C, 0);
      chk("status", exp_ref(5'(c)), q);
      chk("ref_sel", exp_ref(5'(c)), ref_sel);
    end
    repeat (20) begin
      m = $random(seed);
      apb(1, 12'h004, m);
      apb(1, 12'h008, ~m);
      apb(0, 12'h004, 0);
      chk("mask lo", m & 32'h7FFF, q);
      apb(0, 12'h008, 0);
      chk("mask hi", ~m & 32'h0FFF, q);
      chk("dbuf", {~m[11:0], 1'b0, m[14:0]}, dig_buf_off);
    end
    apb(1, 12'h014, 0);
    chk("slverr", 1, s);
    apb(0, 12'h004, 0);
    chk("kept", m & 32'h7FFF, q);
    for (int au = 0; au < 2; au++) begin
      apb(1, 12'h004, 0);
      apb(1, 12'h008, 0);
      auto_mask_en <= au[0];
      m = 0;
      for (int c = 0; c < 28; c++) begin
        @(posedge pclk);
        chan_use <= {1'b1, 5'(c)};
        @(posedge pclk);
        chan_use <= 6'h00;
        if (au == 1 && c != 15) m[c] = 1;
      end
      repeat (2) @(posedge pclk);
      chk("auto", m, dig_buf_off);
    end
    apb(1, 12'h004, 0);
    repeat (2) @(posedge pclk);
    clk_en <= 0;
    @(posedge pclk);
    chan_use <= {1'b1, 5'h03};
    @(posedge pclk);
    chan_use <= 6'h00;
    clk_en <= 1;
    repeat (2) @(posedge pclk);
    chk("frozen", m & 32'h0FFF0000, dig_buf_off);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h008, 0);
    chk("reset hi", 0, q);
    chk("reset pins", 0, dig_buf_off);
    chk("reset ref", 0, ref_sel);
    chk("reset conn", 28'hFFFFFFF, adc_connect);
    print_verdict;
  end
endmodule : arpm_tb_top
`default_nettype wire
